//--- include/mode_cfg_defs.svh
// timing counts, field positions and register offsets for the mode-register programmer
// assumes a 50 MHz ref_clk; included by bare name
`ifndef MODE_CFG_DEFS_SVH
`define MODE_CFG_DEFS_SVH

// clock period in ps
`define CLK_PERIOD_PS 20000
// mode-register-set to next command, in clocks of the memory
`define TMRD_NCK 4
// mode-register-set update delay, in ns (least time)
`define TMOD_NS 15
`define TMOD_CYC (((`TMOD_NS * 1000) + `CLK_PERIOD_PS - 1) / `CLK_PERIOD_PS)
// self refresh exit to first command, in ns (least time)
`define TXS_NS 170
`define TXS_CYC (((`TXS_NS * 1000) + `CLK_PERIOD_PS - 1) / `CLK_PERIOD_PS)

// apb register offsets
`define OFF_CTRL 12'h000
`define OFF_STATUS 12'h004
`define OFF_CFG1 12'h008
`define OFF_CFG2 12'h00c
`define OFF_SHADOW1 12'h010
`define OFF_SHADOW2 12'h014

// command codes written to the control register
`define CMD_NONE 2'h0
`define CMD_WRITE1 2'h1
`define CMD_WRITE2 2'h2
`define CMD_SREF 2'h3

// bank selects for the three registers reached
`define BA_BASE 3'h0
`define BA_CFG1 3'h1
`define BA_CFG2 3'h2

// field positions in the first auxiliary register
`define C1_DLL_OFF 0
`define C1_WLEV 7
`define C1_QOFF 12
`define C1_TDQS 11
// reserved masks: bits 18, 15:13, 10, 8 and 18, 15:11, 8, 2:0
`define C1_RSVD_MASK 19'h4e500
`define C2_RSVD_MASK 19'h4f907
`define C2_ASR 6
`define C2_SRT 7
// dll reset bit of the base register
`define C0_DLL_RST 8

`endif

//--- include/mode_cfg_pkg.sv
// types for the mode-register programmer
// no assumptions beyond a SystemVerilog tool
package mode_cfg_pkg;

   // command pins towards the memory
   typedef struct packed {
      logic cke;
      logic csN;
      logic rasN;
      logic casN;
      logic weN;
      logic [2:0] ba;
      logic [18:0] addr;
      logic odt;
      logic resetN;
   } dram_cmd_s;

   // apb slave answer
   typedef struct packed {
      logic [31:0] prdata;
      logic pready;
      logic pslverr;
   } apb_rsp_s;

   typedef enum logic [2:0] {
      ST_IDLE,
      ST_ISSUE,
      ST_WAIT,
      ST_SREF,
      ST_SREF_EXIT
   } seq_state_e;

endpackage

//--- verilog/mode_cfg_host.sv
// controller that programs the two auxiliary mode registers of an sdram
// assumes the memory is idle whenever software requests a write; apb from software
`timescale 1ns/10ps
`default_nettype none
`include "mode_cfg_defs.svh"

module mode_cfg_host
   import mode_cfg_pkg::*;
#(
   parameter int X8_PART = 1,
   parameter logic [18:0] BASE_VALUE = 19'h00120
) (
   input wire logic ref_clk,
   input wire logic nrst,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [11:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   output logic dramCke,
   output logic dramCsN,
   output logic dramRasN,
   output logic dramCasN,
   output logic dramWeN,
   output logic [2:0] dramBa,
   output logic [18:0] dramAddr,
   output logic dramOdt,
   output logic dramResetN
);

   localparam int GAP_CYC = (`TMOD_CYC > `TMRD_NCK) ? `TMOD_CYC : `TMRD_NCK;
   localparam int XS_CYC = `TXS_CYC;

   ////////////////////////////////////////////////////////////////////////////
   // functions

   // scrub a first-register image before it leaves
   function automatic logic [18:0] clean1(input logic [18:0] v, input logic x8);
      logic [18:0] r;
      r = v & ~`C1_RSVD_MASK;
      if (!x8) begin
         r[`C1_TDQS] = 1'b0;
      end
      return r;
   endfunction

   // scrub a second-register image before it leaves
   function automatic logic [18:0] clean2(input logic [18:0] v);
      logic [18:0] r;
      r = v & ~`C2_RSVD_MASK;
      if (r[`C2_ASR] && r[`C2_SRT]) begin
         r[`C2_SRT] = 1'b0;
      end
      return r;
   endfunction

   // mode register set command word: all strobes low
   function automatic dram_cmd_s mrs(input logic [2:0] ba, input logic [18:0] a);
      dram_cmd_s c;
      c = '{cke: 1'b1, csN: 1'b0, rasN: 1'b0, casN: 1'b0, weN: 1'b0,
            ba: ba, addr: a, odt: 1'b0, resetN: 1'b1};
      return c;
   endfunction

   ////////////////////////////////////////////////////////////////////////////
   // state

   typedef struct packed {
      seq_state_e st;
      logic [18:0] cfg1;
      logic [18:0] cfg2;
      logic [18:0] shadow1;
      logic [18:0] shadow2;
      logic [1:0] pend;
      logic step;
      logic dllRstNeeded;
      logic inSref;
      logic sticky;
      logic [15:0] cnt;
      dram_cmd_s cmd;
      apb_rsp_s rsp;
   } state_s;

   state_s state_reg;
   state_s state_next;
   logic busy;
   logic dllOn;
   logic [18:0] base;

   assign busy = (state_reg.st != ST_IDLE) || (state_reg.pend != `CMD_NONE);
   assign dllOn = ~state_reg.shadow1[`C1_DLL_OFF];
   assign base = BASE_VALUE | (19'h1 << `C0_DLL_RST);

   // apb slave, command sequencer and pin drive
   always_comb begin
      state_next = state_reg;
      state_next.rsp.pready = 1'b0;
      state_next.rsp.pslverr = 1'b0;
      state_next.cmd = '{cke: state_reg.cmd.cke, csN: 1'b1, rasN: 1'b1, casN: 1'b1,
                         weN: 1'b1, ba: 3'h0, addr: 19'h0, odt: 1'b0, resetN: 1'b1};
      // odt stays low: dll-off and self-refresh use no termination
      state_next.cmd.odt = 1'b0;

      // register access: answer one cycle after setup
      if (psel && !penable) begin
         state_next.rsp.pready = 1'b1;
         state_next.rsp.prdata = 32'h0;
         unique case (paddr)
            `OFF_CTRL: begin
               if (pwrite) begin
                  // in self refresh a new command is accepted, not refused; only a self-refresh command requests the exit
                  if (busy && !(state_reg.st == ST_SREF && state_reg.inSref &&
                                state_reg.pend == `CMD_NONE)) begin
                     state_next.rsp.pslverr = 1'b1;
                  end else begin
                     state_next.pend = pwdata[1:0];
                     state_next.sticky = 1'b0;
                  end
               end
            end
            `OFF_STATUS: begin
               state_next.rsp.prdata = {26'h0, state_reg.sticky, state_reg.dllRstNeeded,
                                        state_reg.inSref, dllOn, busy,
                                        state_reg.st == ST_SREF};
            end
            `OFF_CFG1: begin
               if (pwrite) begin
                  state_next.cfg1 = pwdata[18:0];
               end
               state_next.rsp.prdata = {13'h0, state_reg.cfg1};
            end
            `OFF_CFG2: begin
               if (pwrite) begin
                  state_next.cfg2 = pwdata[18:0];
               end
               state_next.rsp.prdata = {13'h0, state_reg.cfg2};
            end
            `OFF_SHADOW1: state_next.rsp.prdata = {13'h0, state_reg.shadow1};
            `OFF_SHADOW2: state_next.rsp.prdata = {13'h0, state_reg.shadow2};
            default: state_next.rsp.pslverr = 1'b1;
         endcase
      end

      // sequencer
      unique case (state_reg.st)
         ST_IDLE: begin
            if (state_reg.pend != `CMD_NONE) begin
               state_next.st = (state_reg.pend == `CMD_SREF) ? ST_SREF : ST_ISSUE;
               state_next.step = 1'b0;
               state_next.cnt = 16'h0;
            end
         end
         ST_ISSUE: begin
            if (!state_reg.step && state_reg.pend == `CMD_WRITE1) begin
               state_next.cmd = mrs(`BA_CFG1, clean1(state_reg.cfg1, X8_PART == 1));
               state_next.shadow1 = clean1(state_reg.cfg1, X8_PART == 1);
               // dll switched on: queue a dll reset
               state_next.dllRstNeeded = ~state_reg.cfg1[`C1_DLL_OFF] &&
                                         state_reg.shadow1[`C1_DLL_OFF];
            end else if (!state_reg.step) begin
               state_next.cmd = mrs(`BA_CFG2, clean2(state_reg.cfg2));
               state_next.shadow2 = clean2(state_reg.cfg2);
            end else begin
               state_next.cmd = mrs(`BA_BASE, base);
               state_next.dllRstNeeded = 1'b0;
            end
            state_next.cnt = 16'h0;
            state_next.st = ST_WAIT;
         end
         ST_WAIT: begin
            state_next.cnt = state_reg.cnt + 16'h1;
            if (state_reg.cnt >= 16'(GAP_CYC - 1)) begin
               if (!state_reg.step && state_reg.dllRstNeeded) begin
                  state_next.step = 1'b1;
                  state_next.st = ST_ISSUE;
               end else begin
                  state_next.pend = `CMD_NONE;
                  state_next.sticky = 1'b1;
                  state_next.st = ST_IDLE;
               end
            end
         end
         ST_SREF: begin
            // enter on first cycle, leave when software writes the self-refresh command again
            if (!state_reg.inSref) begin
               state_next.cmd = '{cke: 1'b0, csN: 1'b0, rasN: 1'b0, casN: 1'b0, weN: 1'b1,
                                  ba: 3'h0, addr: 19'h0, odt: 1'b0, resetN: 1'b1};
               state_next.inSref = 1'b1;
               state_next.pend = `CMD_NONE;
            end else if (state_reg.pend == `CMD_SREF) begin
               state_next.cmd.cke = 1'b1;
               state_next.cnt = 16'h0;
               state_next.st = ST_SREF_EXIT;
            end
         end
         ST_SREF_EXIT: begin
            state_next.cnt = state_reg.cnt + 16'h1;
            if (state_reg.cnt >= 16'(XS_CYC - 1)) begin
               // memory restores a dll that was on; one that was off stays off
               state_next.inSref = 1'b0;
               state_next.pend = `CMD_NONE;
               state_next.sticky = 1'b1;
               state_next.st = ST_IDLE;
            end
         end
         default: state_next.st = ST_IDLE;
      endcase
   end

   // state register; second sref command request exits self refresh
   always_ff @(posedge ref_clk or negedge nrst) begin
      if (!nrst) begin
         state_reg <= '{st: ST_IDLE, cfg1: 19'h0, cfg2: 19'h0, shadow1: 19'h0,
                        shadow2: 19'h0, pend: 2'h0, step: 1'b0, dllRstNeeded: 1'b0,
                        inSref: 1'b0, sticky: 1'b0, cnt: 16'h0,
                        cmd: '{cke: 1'b1, csN: 1'b1, rasN: 1'b1, casN: 1'b1, weN: 1'b1,
                               ba: 3'h0, addr: 19'h0, odt: 1'b0, resetN: 1'b1},
                        rsp: '{prdata: 32'h0, pready: 1'b0, pslverr: 1'b0}};
      end else begin
         state_reg <= state_next;
      end
   end

   // outputs straight from the state flops
   assign prdata = state_reg.rsp.prdata;
   assign pready = state_reg.rsp.pready;
   assign pslverr = state_reg.rsp.pslverr;
   assign dramCke = state_reg.cmd.cke;
   assign dramCsN = state_reg.cmd.csN;
   assign dramRasN = state_reg.cmd.rasN;
   assign dramCasN = state_reg.cmd.casN;
   assign dramWeN = state_reg.cmd.weN;
   assign dramBa = state_reg.cmd.ba;
   assign dramAddr = state_reg.cmd.addr;
   assign dramOdt = state_reg.cmd.odt;
   assign dramResetN = state_reg.cmd.resetN;

endmodule // mode_cfg_host
`default_nettype wire

//--- tb/mode_cfg_properties.sv
// concurrent checks on the command pins of the mode-register programmer
// bound to mode_cfg_host; sees its ports only
`timescale 1ns/10ps
`default_nettype none
`include "mode_cfg_defs.svh"

module mode_cfg_checker
   import mode_cfg_pkg::*;
#(
   parameter int X8_PART = 1,
   parameter logic [18:0] BASE_VALUE = 19'h00120
) (
   input wire logic ref_clk,
   input wire logic nrst,
   input wire logic dramCke,
   input wire logic dramCsN,
   input wire logic dramRasN,
   input wire logic dramCasN,
   input wire logic dramWeN,
   input wire logic [2:0] dramBa,
   input wire logic [18:0] dramAddr,
   input wire logic dramOdt
);
   logic mrs;
   logic dllOff_reg;
   logic seen_reg;
   // mode register set decode
   assign mrs = !dramCsN && !dramRasN && !dramCasN && !dramWeN;
   // last dll bit sent to the first register
   always_ff @(posedge ref_clk or negedge nrst) begin
      if (!nrst) begin
         dllOff_reg <= 1'b0;
         seen_reg <= 1'b0;
      end else if (mrs && dramBa == `BA_CFG1) begin
         dllOff_reg <= dramAddr[0];
         seen_reg <= 1'b1;
      end
   end
   ////////////////////////////////////////////////////////////////////////////////
   default clocking cb @(posedge ref_clk); endclocking
   default disable iff (!nrst);
   sequence s_cfg1; mrs && dramBa == `BA_CFG1; endsequence
   sequence s_cfg2; mrs && dramBa == `BA_CFG2; endsequence
   sequence s_dllrst; mrs && dramBa == `BA_BASE && dramAddr == (BASE_VALUE | 19'h00100); endsequence
   property p_gap; mrs |=> (!mrs)[*4]; endproperty
   a_gap: assert property (p_gap) else $error("commands too close");
   property p_rsvd1; s_cfg1 |-> (dramAddr & `C1_RSVD_MASK) == 19'h00000; endproperty
   a_rsvd1: assert property (p_rsvd1) else $error("reserved bit set in cfg1");
   property p_rsvd2; s_cfg2 |-> (dramAddr & `C2_RSVD_MASK) == 19'h00000; endproperty
   a_rsvd2: assert property (p_rsvd2) else $error("reserved bit set in cfg2");
   property p_asr; s_cfg2 |-> !(dramAddr[`C2_ASR] && dramAddr[`C2_SRT]); endproperty
   a_asr: assert property (p_asr) else $error("asr and srt together");
   property p_tdqs; s_cfg1 and X8_PART == 0 |-> !dramAddr[`C1_TDQS]; endproperty
   a_tdqs: assert property (p_tdqs) else $error("tdqs on wrong width");
   property p_dllrst; s_cfg1 ##0 (!dramAddr[0] && seen_reg && dllOff_reg) |-> ##[5:12] s_dllrst;
   endproperty
   a_dllrst: assert property (p_dllrst) else $error("no dll reset after enable");
   property p_odt; $past(nrst) |-> !dramOdt && !$rose(dramOdt); endproperty
   a_odt: assert property (p_odt) else $error("odt driven");
   property p_sref; $fell(dramCke) |-> !dramCsN && !dramRasN && !dramCasN && dramWeN; endproperty
   a_sref: assert property (p_sref) else $error("bad self refresh entry");
endmodule // mode_cfg_checker

bind mode_cfg_host mode_cfg_checker #(.X8_PART(X8_PART), .BASE_VALUE(BASE_VALUE)) chk (
   .ref_clk(ref_clk), .nrst(nrst), .dramCke(dramCke), .dramCsN(dramCsN),
   .dramRasN(dramRasN), .dramCasN(dramCasN), .dramWeN(dramWeN), .dramBa(dramBa),
   .dramAddr(dramAddr), .dramOdt(dramOdt));
`default_nettype wire

//--- tb/mode_reg_model.sv
// behavioural sdram mode registers driven by the command pins
// assumes mode register set is all strobes low for one cycle
`timescale 1ns/10ps
`default_nettype none
`include "mode_cfg_defs.svh"

module mode_reg_model (
   input wire logic ref_clk,
   input wire logic dramCke,
   input wire logic dramCsN,
   input wire logic dramRasN,
   input wire logic dramCasN,
   input wire logic dramWeN,
   input wire logic [2:0] dramBa,
   input wire logic [18:0] dramAddr,
   input wire logic dramOdt,
   input wire logic dramResetN,
   output logic [18:0] baseCfg = 19'h00000,
   output logic [18:0] termLatCfg = 19'h00000,
   output logic [18:0] wrLatRefCfg = 19'h00000,
   output logic dllOn = 1'b0,
   output logic [7:0] rstCnt = 8'h00
);
   logic mrs;
   logic ckePrev = 1'b1;
   logic dqOutEn, dmEn, termOn, dynOdt, wlevAll;
   // pin behaviour implied by the stored fields
   assign mrs = !dramCsN && !dramRasN && !dramCasN && !dramWeN;
   assign dqOutEn = !termLatCfg[12];
   assign dmEn = !termLatCfg[11];
   assign termOn = dramOdt && |{termLatCfg[9], termLatCfg[6], termLatCfg[2]};
   assign dynOdt = |wrLatRefCfg[10:9];
   assign wlevAll = termLatCfg[7] && termLatCfg[12];
   // register loads, dll and self refresh
   always @(posedge ref_clk) begin
      ckePrev <= dramCke;
      if (!dramResetN) termLatCfg <= 19'h00000;
      else if (mrs && dramBa == `BA_CFG1) termLatCfg <= dramAddr;
      if (mrs && dramBa == `BA_CFG1) dllOn <= !dramAddr[0];
      if (mrs && dramBa == `BA_CFG2) wrLatRefCfg <= dramAddr;
      if (mrs && dramBa == `BA_BASE) baseCfg <= dramAddr & ~19'h00100;
      if (mrs && dramBa == `BA_BASE && dramAddr[8]) rstCnt <= rstCnt + 8'h01;
      if (ckePrev && !dramCke) dllOn <= 1'b0;
      if (!ckePrev && dramCke) begin
         dllOn <= !termLatCfg[0];
         rstCnt <= rstCnt + {7'h00, !termLatCfg[0]};
      end
   end
endmodule // mode_reg_model
`default_nettype wire

//--- tb/mode_cfg_host_tb_top.sv
// self-checking bench for the mode-register programmer
// apb master tasks, device model on the command pins, checker bound in
`timescale 1ns/10ps
`default_nettype none
`include "mode_cfg_defs.svh"

module mode_cfg_host_tb_top;
   import mode_cfg_pkg::*;
   localparam logic [18:0] BASE = 19'h00120;
   logic ref_clk = 1'b0, nrst = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
   logic [11:0] paddr = 12'h000;
   logic [31:0] pwdata = 32'h00000000, prdata, q;
   logic pready, pslverr, e, dramCke, dramCsN, dramRasN, dramCasN, dramWeN, dramOdt, dramResetN;
   logic dllOn;
   logic [2:0] dramBa;
   logic [18:0] dramAddr, m0, m1, m2;
   logic [7:0] rstCnt, n0;
   int errCount = 0, checkCount = 0;
   always #10 ref_clk = ~ref_clk;
   mode_cfg_host #(.X8_PART(0), .BASE_VALUE(BASE)) dut (.ref_clk(ref_clk), .nrst(nrst),
      .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
      .prdata(prdata), .pready(pready), .pslverr(pslverr), .dramCke(dramCke),
      .dramCsN(dramCsN), .dramRasN(dramRasN), .dramCasN(dramCasN), .dramWeN(dramWeN),
      .dramBa(dramBa), .dramAddr(dramAddr), .dramOdt(dramOdt), .dramResetN(dramResetN));
   mode_reg_model mem (.ref_clk(ref_clk), .dramCke(dramCke), .dramCsN(dramCsN),
      .dramRasN(dramRasN), .dramCasN(dramCasN), .dramWeN(dramWeN), .dramBa(dramBa),
      .dramAddr(dramAddr), .dramOdt(dramOdt), .dramResetN(dramResetN), .baseCfg(m0),
      .termLatCfg(m1), .wrLatRefCfg(m2), .dllOn(dllOn), .rstCnt(rstCnt));
   ////////////////////////////////////////////////////////////////////////////////
   task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
      checkCount++;
      if (got !== exp) begin
         errCount++;
         $display("mismatch %s expected %h seen %h", what, exp, got);
      end
   endtask
   // one apb transfer, entered just after an edge
   task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
      psel <= 1'b1;
      pwrite <= wr;
      paddr <= a;
      pwdata <= d;
      @(posedge ref_clk);
      penable <= 1'b1;
      for (int n = 0; n < 20; n++) begin
         @(posedge ref_clk);
         if (pready === 1'b1) break;
      end
      chk("pready", 1, pready);
      q = prdata;
      e = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
      @(posedge ref_clk);
   endtask
   task automatic wait_st(input int b, input logic v);
      for (int i = 0; i < 60; i++) begin
         apb(1'b0, `OFF_STATUS, 32'h0);
         if (q[b] === v) return;
      end
      chk("status wait", 0, 1);
   endtask
   task automatic close_out();
      if (errCount == 0 && checkCount > 0) $display("No errors found");
      else $display("Errors were found");
      $finish;
   endtask
   ////////////////////////////////////////////////////////////////////////////////
   // reserved bits, width-limited tdqs, refusal while busy
   task automatic t_cfg1();
      apb(1'b1, `OFF_CFG1, 32'h0007ffff);
      apb(1'b1, `OFF_CTRL, 32'h1);
      apb(1'b1, `OFF_CTRL, 32'h2);
      chk("busy refusal", 1, e);
      wait_st(1, 1'b0);
      chk("cfg1", 19'h7ffff & ~`C1_RSVD_MASK & ~19'h00800, m1);
      chk("cfg2 untouched", 0, m2);
      chk("dll off", 0, dllOn);
   endtask
   // enabling the dll brings a dll reset
   task automatic t_dll();
      n0 = rstCnt;
      apb(1'b1, `OFF_CFG1, 32'h00046);
      apb(1'b1, `OFF_CTRL, 32'h1);
      wait_st(1, 1'b0);
      chk("cfg1", 32'h46, m1);
      chk("base", BASE & ~19'h00100, m0);
      chk("dll resets", n0 + 8'h01, rstCnt);
      chk("dll on", 1, dllOn);
   endtask
   task automatic t_cfg2();
      apb(1'b1, `OFF_CFG2, 32'h0007ffff);
      apb(1'b1, `OFF_CTRL, 32'h2);
      wait_st(1, 1'b0);
      chk("cfg2", 19'h7ffff & ~`C2_RSVD_MASK & ~19'h00080, m2);
   endtask
   task automatic t_sref(input logic [31:0] c1, input logic on);
      apb(1'b1, `OFF_CFG1, c1);
      apb(1'b1, `OFF_CTRL, 32'h1);
      wait_st(1, 1'b0);
      n0 = rstCnt;
      apb(1'b1, `OFF_CTRL, 32'h3);
      wait_st(3, 1'b1);
      chk("cke in sref", 0, dramCke);
      chk("dll in sref", 0, dllOn);
      apb(1'b1, `OFF_CTRL, 32'h3);
      wait_st(3, 1'b0);
      wait_st(1, 1'b0);
      chk("cke after", 1, dramCke);
      chk("dll after", on, dllOn);
      chk("dll resets", n0 + {7'h00, on}, rstCnt);
   endtask
   ////////////////////////////////////////////////////////////////////////////////
   initial begin
      repeat (20000) @(posedge ref_clk);
      errCount++;
      close_out();
   end
   initial begin
      repeat (4) @(posedge ref_clk);
      nrst <= 1'b1;
      @(posedge ref_clk);
      chk("cke after reset", 1, dramCke);
      t_cfg1();
      t_dll();
      t_cfg2();
      t_sref(32'h00046, 1'b1);
      t_sref(32'h00047, 1'b0);
      apb(1'b0, 12'h020, 32'h0);
      chk("unmapped err", 1, e);
      chk("unmapped data", 0, q);
      close_out();
   end
endmodule // mode_cfg_host_tb_top
`default_nettype wire
